// ### rtl/accel_output_and_init.sv
// Operation
// - interpolate sixteen steps per sample period
// - delay each result one sample period
// - answer request from two latest samples
// - clip 26-bit result to 10/9/8-bit word
// - truncate bits 21:12, 21:13 or 21:14
// - test stream only when config bit set
// - 4 MHz pulse stream from top 9 bits
// - restart init on power, undervoltage, clear
// - power-up: known state, no answer
// - after clear: init 1, self-test 0, silent
// - copy fuses to mirrors, stay silent
// - after link delay accept messages, init 1
// - short read during filter init returns zero
// - long read during filter init is invalid
// - after filter delay data valid, init 0
// - sample period is 16:1 decimation period
`timescale 1ns/100ps
`include "accel_out_defines.svh"

module accel_output_and_init import accel_out_pkg::*; #(
    parameter int P_FILT_CYC = `FILT_CYC
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // processing chain samples
    input wire logic i_sample_valid,
    input wire logic [25:0] i_sample_data,
    // bus side request and restart sources
    input wire logic i_accel_req,
    input wire logic i_accel_long,
    input wire logic i_clear_cmd,
    input wire logic i_uv_rst,
    // fuse array
    input wire logic [7:0] i_fuse_data,
    output logic [3:0] o_fuse_addr,
    // answer and status
    output logic o_accel_valid,
    output logic [9:0] o_accel_data,
    output logic o_accel_invalid,
    output logic o_init_flag,
    output logic o_self_test_active_flag,
    output logic o_bus_ready,
    output logic o_pcm,
    output logic o_irq,
    // axi4-lite slave
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);

    // truncating scaler; clip first so the slice saturates instead of wrapping
    function automatic logic [9:0] scale_word(input logic signed [31:0] v, input word_sel_t sel);
        logic signed [31:0] c;
        c = (v > `CLIP_MAX) ? `CLIP_MAX : ((v < `CLIP_MIN) ? `CLIP_MIN : v);
        case (sel)
            W9: scale_word = {1'b0, c[21:13]};
            W8: scale_word = {2'b00, c[21:14]};
            default: scale_word = c[21:12];
        endcase
    endfunction : scale_word

    // ----------------------------------------
    // initialization sequencer
    // ----------------------------------------
    init_state_t state_q, state_d;
    logic [16:0] wait_q;
    logic [3:0] fuse_idx_q;
    logic [7:0] mirror_q [`FUSE_WORDS];
    logic [3:0] cfg_q;
    wire restart = i_clear_cmd | i_uv_rst;
    wire link_done = wait_q == 17'(`LINK_CYC - 1);
    wire filt_done = wait_q == 17'(P_FILT_CYC - 1);
    wire fuse_last = fuse_idx_q == 4'(`FUSE_WORDS - 1);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: state_d = ST_FUSE;
            ST_FUSE: if (fuse_last) state_d = ST_LINK;
            ST_LINK: if (link_done) state_d = ST_FILT;
            ST_FILT: if (filt_done) state_d = ST_RUN;
            ST_RUN: state_d = ST_RUN;
            default: state_d = ST_RESET;
        endcase
        if (restart) begin
            state_d = ST_RESET;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_RESET;
            wait_q <= '0;
            fuse_idx_q <= '0;
        end else begin
            state_q <= state_d;
            wait_q <= (state_d != state_q) ? 17'd0 : wait_q + 17'd1;
            fuse_idx_q <= (state_q == ST_FUSE) ? fuse_idx_q + 4'd1 : 4'd0;
        end
    end

    // fuse data is valid for the address presented in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (state_q == ST_FUSE) begin
            mirror_q[fuse_idx_q] <= i_fuse_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_init_flag <= 1'b1;
            o_self_test_active_flag <= 1'b0;
            o_bus_ready <= 1'b0;
            o_fuse_addr <= '0;
        end else begin
            o_init_flag <= state_d != ST_RUN;
            o_self_test_active_flag <= (state_d == ST_RUN) & cfg_q[`CFG_ST];
            o_bus_ready <= state_d inside {ST_FILT, ST_RUN};
            o_fuse_addr <= (state_d == ST_FUSE && state_q == ST_FUSE) ? fuse_idx_q + 4'd1 : 4'd0;
        end
    end

    // ----------------------------------------
    // sample delay and interpolation
    // ----------------------------------------
    logic signed [25:0] s_new_q, s_old_q;
    logic [3:0] phase_q;
    logic [5:0] step_q;
    wire step_end = step_q == 6'(`STEP_CYC - 1);
    wire signed [26:0] diff = {s_new_q[25], s_new_q} - {s_old_q[25], s_old_q};
    wire signed [31:0] prod = diff * $signed({1'b0, phase_q});
    wire signed [31:0] ip_sum = {{6{s_old_q[25]}}, s_old_q} + (prod >>> 4);
    wire word_sel_t wsel = word_sel_t'(cfg_q[`CFG_WSEL_HI:`CFG_WSEL_LO]);
    wire [9:0] word = scale_word(ip_sum, wsel);
    wire [9:0] word9 = scale_word(ip_sum, W9);

    // the newest sample is only an end point; output trails by one period
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_new_q <= '0;
            s_old_q <= '0;
            phase_q <= '0;
            step_q <= '0;
        end else if (i_sample_valid) begin
            s_old_q <= s_new_q;
            s_new_q <= i_sample_data;
            phase_q <= '0;
            step_q <= '0;
        end else begin
            step_q <= step_end ? 6'd0 : step_q + 6'd1;
            if (step_end && phase_q != 4'hF) begin
                phase_q <= phase_q + 4'd1;
            end
        end
    end

    // ----------------------------------------
    // request answer
    // ----------------------------------------
    wire req_ok = i_accel_req & o_bus_ready;
    wire filt_busy = state_q != ST_RUN;

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_accel_valid <= 1'b0;
            o_accel_data <= '0;
            o_accel_invalid <= 1'b0;
        end else begin
            o_accel_valid <= req_ok;
            if (req_ok) begin
                o_accel_data <= (filt_busy && !i_accel_long) ? 10'h000 : word;
                o_accel_invalid <= filt_busy;
            end
        end
    end

    // ----------------------------------------
    // pulse-code test output
    // ----------------------------------------
    logic [3:0] pcm_div_q;
    logic [8:0] pcm_acc_q;
    wire pcm_tick = pcm_div_q == 4'(`PCM_DIV - 1);
    wire [8:0] pcm_in = {~word9[8], word9[7:0]};
    wire [9:0] pcm_sum = {1'b0, pcm_acc_q} + {1'b0, pcm_in};

    // first-order modulator: density of ones tracks the offset-binary word
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pcm_div_q <= '0;
            pcm_acc_q <= '0;
            o_pcm <= 1'b0;
        end else if (!cfg_q[`CFG_PCM]) begin
            pcm_div_q <= '0;
            pcm_acc_q <= '0;
            o_pcm <= 1'b0;
        end else begin
            pcm_div_q <= pcm_tick ? 4'd0 : pcm_div_q + 4'd1;
            if (pcm_tick) begin
                pcm_acc_q <= pcm_sum[8:0];
                o_pcm <= pcm_sum[9];
            end
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    logic [2:0] irq_stat_q, irq_mask_q;
    logic [2:0] irq_clr;
    wire [2:0] irq_set = {restart, req_ok, state_q != ST_RUN && state_d == ST_RUN};
    wire [2:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;

    // ----------------------------------------
    // axi4-lite slave
    // ----------------------------------------
    logic aw_hold_q, w_hold_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wstrb0_q;
    wire aw_take = i_s_axi_awvalid & o_s_axi_awready;
    wire w_take = i_s_axi_wvalid & o_s_axi_wready;
    wire do_write = aw_hold_q & w_hold_q & ~o_s_axi_bvalid;
    wire aw_hold_d = aw_hold_q ? ~do_write : aw_take;
    wire w_hold_d = w_hold_q ? ~do_write : w_take;
    wire wr_cfg = do_write && wstrb0_q && awaddr_q == `A_CFG;
    wire wr_stat = do_write && wstrb0_q && awaddr_q == `A_IRQ_STAT;
    wire wr_mask = do_write && wstrb0_q && awaddr_q == `A_IRQ_MASK;
    wire wr_known = awaddr_q == `A_CFG || awaddr_q == `A_IRQ_STAT || awaddr_q == `A_IRQ_MASK;
    wire ar_take = i_s_axi_arvalid & o_s_axi_arready;
    logic [31:0] rd_data;
    logic rd_known;

    assign irq_clr = wr_stat ? wdata_q[2:0] : 3'b000;

    always_comb begin
        rd_known = 1'b1;
        if (i_s_axi_araddr == `A_CFG) begin
            rd_data = {28'h000_0000, cfg_q};
        end else if (i_s_axi_araddr == `A_STATUS) begin
            rd_data = {26'h000_0000, state_q, o_bus_ready, o_self_test_active_flag, o_init_flag};
        end else if (i_s_axi_araddr == `A_IRQ_STAT) begin
            rd_data = {29'h0000_0000, irq_stat_q};
        end else if (i_s_axi_araddr == `A_IRQ_MASK) begin
            rd_data = {29'h0000_0000, irq_mask_q};
        end else if (i_s_axi_araddr == `A_LAST) begin
            rd_data = {21'h00_0000, o_accel_invalid, o_accel_data};
        end else if (i_s_axi_araddr[7:6] == `A_MIRROR_HI) begin
            rd_data = {24'h00_0000, mirror_q[i_s_axi_araddr[5:2]]};
        end else begin
            rd_data = 32'h0000_0000;
            rd_known = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `RESP_OKAY;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            o_s_axi_awready <= ~aw_hold_d;
            o_s_axi_wready <= ~w_hold_d;
            if (aw_take) begin
                awaddr_q <= i_s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= i_s_axi_wdata;
                wstrb0_q <= i_s_axi_wstrb[0];
            end
            if (do_write) begin
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_s_axi_arready <= 1'b1;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= '0;
            o_s_axi_rresp <= `RESP_OKAY;
        end else if (ar_take) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rdata <= rd_data;
            o_s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
        end else if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_arready <= 1'b1;
        end
    end

    // configuration survives a restart; only the sequence itself reruns
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_q <= `CFG_RST;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            o_irq <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_q <= wdata_q[3:0];
            end
            if (wr_mask) begin
                irq_mask_q <= wdata_q[2:0];
            end
            irq_stat_q <= irq_stat_d;
            o_irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    restart_seq_a: assert property (restart |=> state_q == ST_RESET && o_init_flag)
        else $error("restart did not reenter reset state");
    silent_init_a: assert property (state_q inside {ST_RESET, ST_FUSE, ST_LINK} && i_accel_req
        |=> !o_accel_valid)
        else $error("answer given before link ready");
    flags_init_a: assert property (state_q != ST_RUN |-> o_init_flag && !o_self_test_active_flag)
        else $error("flags wrong during init");
    short_zero_a: assert property (state_q == ST_FILT && i_accel_req && !i_accel_long
        |=> o_accel_valid && o_accel_data == 10'h000 && o_accel_invalid)
        else $error("short read not zero during filter init");
    link_time_a: assert property (state_q == ST_LINK && !restart ##1 state_q == ST_FILT
        |-> $past(wait_q) == 17'(`LINK_CYC - 1) && o_bus_ready)
        else $error("link delay wrong");
    run_flag_a: assert property ($rose(state_q == ST_RUN) |-> !o_init_flag)
        else $error("init flag not cleared");
    hold_back_a: assert property (i_sample_valid |=> s_old_q == $past(s_new_q) && phase_q == 4'h0)
        else $error("sample not delayed one period");
    phase_step_a: assert property (step_end && !i_sample_valid && phase_q != 4'hF
        |=> phase_q == $past(phase_q) + 4'd1)
        else $error("phase did not advance");
    trunc_a: assert property (wsel == W8 && ip_sum <= `CLIP_MAX && ip_sum >= `CLIP_MIN
        |-> word == {2'b00, ip_sum[21:14]})
        else $error("8-bit truncation wrong");
    clip_a: assert property (wsel == W10 && ip_sum > `CLIP_MAX |-> word == 10'h1FF)
        else $error("clip wrapped");
    pcm_off_a: assert property (!cfg_q[`CFG_PCM] |=> !o_pcm)
        else $error("test stream active while disabled");

    reach_run_c: cover property ($rose(state_q == ST_RUN));
    served_c: cover property (state_q == ST_RUN && i_accel_req ##1 o_accel_valid);
    pcm_c: cover property (cfg_q[`CFG_PCM] && o_pcm);
    irq_c: cover property ($rose(o_irq));

endmodule : accel_output_and_init

// ### rtl/accel_out_defines.svh
`ifndef ACCEL_OUT_DEFINES_SVH
`define ACCEL_OUT_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 40
`define CLK_NS 25
`define T_SAMPLE_NS 16000
`define INTERP_STEPS 16
`define STEP_CYC ((`T_SAMPLE_NS / `CLK_NS) / `INTERP_STEPS)
`define PCM_MHZ 4
`define PCM_DIV (`CLK_MHZ / `PCM_MHZ)
`define T_LINK_US 50
`define LINK_CYC (`T_LINK_US * `CLK_MHZ)
`define T_FILT_US 2000
`define FILT_CYC (`T_FILT_US * `CLK_MHZ)
`define FUSE_WORDS 16

// ----------------------------------------
// output scaling
// ----------------------------------------
`define CLIP_MAX 32'sh001F_FFFF
`define CLIP_MIN 32'shFFE0_0000

// ----------------------------------------
// register map
// ----------------------------------------
`define A_CFG 8'h00
`define A_STATUS 8'h04
`define A_IRQ_STAT 8'h08
`define A_IRQ_MASK 8'h0C
`define A_LAST 8'h10
`define A_MIRROR_HI 2'b01
`define CFG_PCM 0
`define CFG_WSEL_LO 1
`define CFG_WSEL_HI 2
`define CFG_ST 3
`define CFG_RST 4'h0
`define IRQ_READY 0
`define IRQ_SERVED 1
`define IRQ_RESTART 2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### rtl/accel_out_pkg.sv
package accel_out_pkg;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_FUSE = 3'b001,
        ST_LINK = 3'b010,
        ST_FILT = 3'b011,
        ST_RUN = 3'b100
    } init_state_t;

    typedef enum logic [1:0] {
        W10 = 2'b00,
        W9 = 2'b01,
        W8 = 2'b10
    } word_sel_t;

endpackage : accel_out_pkg

// ### bench/bus_master_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// far-side bus master: requests, clears
// ----------------------------------------
module bus_master_model (
    // clock
    input wire logic i_ref_clk,
    // device answer
    input wire logic i_accel_valid,
    input wire logic [9:0] i_accel_data,
    input wire logic i_accel_invalid,
    // commands to device
    output logic o_accel_req,
    output logic o_accel_long,
    output logic o_clear_cmd
);
    logic [9:0] good_q = 10'h000;

    initial begin
        o_accel_req = 1'b0;
        o_accel_long = 1'b0;
        o_clear_cmd = 1'b0;
    end

    // sends even while the device is not ready, as a real master may
    task automatic request(input logic lng, output logic got, output logic [9:0] dat, output logic inv);
        @(posedge i_ref_clk);
        o_accel_req <= 1'b1;
        o_accel_long <= lng;
        @(posedge i_ref_clk);
        o_accel_req <= 1'b0;
        #1;
        got = i_accel_valid;
        dat = i_accel_data;
        inv = i_accel_invalid;
        if (got === 1'b1 && inv === 1'b0) begin
            good_q = dat;
        end
    endtask : request

    task automatic clear();
        @(posedge i_ref_clk);
        o_clear_cmd <= 1'b1;
        @(posedge i_ref_clk);
        o_clear_cmd <= 1'b0;
    endtask : clear
endmodule : bus_master_model

// ### bench/accel_output_and_init_tb.sv
`timescale 1ns/100ps
`include "accel_out_defines.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module accel_output_and_init_tb import accel_out_pkg::*;;
    localparam int FILT = 100;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic s_vld = 1'b0;
    logic uv = 1'b0;
    logic [25:0] s_dat = 26'h000_0000;
    logic req, lng, clr, a_vld, a_inv, init_f, st_f, b_rdy, pcm, irq;
    logic [3:0] f_addr;
    logic [9:0] a_dat, dv;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata, rd;
    logic awready, wready, bvalid, arready, rvalid, g, inv;
    logic [1:0] bresp, rresp, rs;
    logic [25:0] sv [3] = '{26'h1FF_FFFF, 26'h200_0000, 26'h008_0000};
    logic [9:0] e10 [3] = '{10'h1FF, 10'h200, 10'h080};
    int error_cnt = 0;
    int checks = 0;

    always #12.5 clk = ~clk;

    accel_output_and_init #(.P_FILT_CYC(FILT)) i_accel_output_and_init (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_sample_valid(s_vld), .i_sample_data(s_dat),
        .i_accel_req(req), .i_accel_long(lng), .i_clear_cmd(clr), .i_uv_rst(uv),
        .i_fuse_data({4'ha, f_addr}), .o_fuse_addr(f_addr), .o_accel_valid(a_vld),
        .o_accel_data(a_dat), .o_accel_invalid(a_inv), .o_init_flag(init_f),
        .o_self_test_active_flag(st_f), .o_bus_ready(b_rdy), .o_pcm(pcm), .o_irq(irq),
        .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
        .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
        .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
        .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
        .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
        .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready));

    bus_master_model i_bus_master_model (
        .i_ref_clk(clk), .i_accel_valid(a_vld), .i_accel_data(a_dat), .i_accel_invalid(a_inv),
        .o_accel_req(req), .o_accel_long(lng), .o_clear_cmd(clr));

    // ----------------------------------------
    // bus and stimulus tasks
    // ----------------------------------------
    // handshakes are judged mid-cycle, on the values the next rising edge will see
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_go, w_go, b_go;
        b_go = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_go) begin
            @(negedge clk);
            aw_go = awready;
            w_go = wready;
            b_go = bvalid;
            r = bresp;
            @(posedge clk);
            if (aw_go) awvalid <= 1'b0;
            if (w_go) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_go, r_go;
        r_go = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_go) begin
            @(negedge clk);
            ar_go = arready;
            r_go = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ar_go) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int n = 0; n < lim && s !== v; n++) @(posedge clk);
        `CHK(s, v)
    endtask : wait_for

    // a sample is captured at the edge where this task returns
    task automatic sample(input logic [25:0] d);
        @(posedge clk);
        s_vld <= 1'b1;
        s_dat <= d;
        @(posedge clk);
        s_vld <= 1'b0;
    endtask : sample

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power_up;
        `CHK(init_f, 1'b1)
        `CHK(b_rdy, 1'b0)
        axi_rd(`A_CFG, rd, rs);
        `CHK(rd, 32'h0000_0000)
        repeat (40) @(posedge clk);
        for (int k = 0; k < `FUSE_WORDS; k++) begin
            axi_rd(8'h40 + 8'(4 * k), rd, rs);
            `CHK(rd, {24'h00_0000, 4'ha, k[3:0]})
        end
        i_bus_master_model.request(1'b0, g, dv, inv);
        `CHK(g, 1'b0)
        wait_for(b_rdy, 1'b1, `LINK_CYC + 100);
        `CHK(init_f, 1'b1)
        i_bus_master_model.request(1'b0, g, dv, inv);
        `CHK(g, 1'b1)
        `CHK(dv, 10'h000)
        i_bus_master_model.request(1'b1, g, dv, inv);
        `CHK(inv, 1'b1)
        wait_for(init_f, 1'b0, FILT + 100);
        `CHK(st_f, 1'b0)
        axi_rd(`A_STATUS, rd, rs);
        `CHK(rd[5:0], {ST_RUN, 3'b100})
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_interp;
        sample(26'h000_0000);
        sample(26'h000_0000);
        sample(26'h010_0000);
        i_bus_master_model.request(1'b0, g, dv, inv);
        `CHK(dv, 10'h000)
        repeat (330) @(posedge clk);
        i_bus_master_model.request(1'b1, g, dv, inv);
        `CHK(inv, 1'b0)
        `CHK(dv, 10'h080)
        repeat (360) @(posedge clk);
        i_bus_master_model.request(1'b0, g, dv, inv);
        `CHK(dv, 10'h0F0)
        axi_rd(`A_LAST, rd, rs);
        `CHK(rd[10:0], 11'h0F0)
        $display("test interp done");
    endtask : t_interp

    task automatic t_scale;
        for (int w = 0; w < 3; w++) begin
            axi_wr(`A_CFG, 32'(2 * w), rs);
            for (int i = 0; i < 3; i++) begin
                sample(sv[i]);
                sample(sv[i]);
                i_bus_master_model.request(1'b0, g, dv, inv);
                `CHK(dv, e10[i] >> w)
            end
        end
        axi_wr(`A_CFG, 32'h0000_0000, rs);
        $display("test scale done");
    endtask : t_scale

    task automatic t_pcm;
        int ones;
        ones = 0;
        for (int n = 0; n < 200; n++) @(posedge clk) ones += (pcm === 1'b1);
        `CHK(ones, 0)
        axi_wr(`A_CFG, 32'h0000_0001, rs);
        repeat (20) @(posedge clk);
        // word 0x080, top nine bits 64, offset 320 of 512
        for (int n = 0; n < 5120; n++) @(posedge clk) ones += (pcm === 1'b1);
        `CHK(ones >= 3180 && ones <= 3220, 1'b1)
        axi_wr(`A_CFG, 32'h0000_0000, rs);
        $display("test pcm done");
    endtask : t_pcm

    task automatic t_irq;
        axi_wr(`A_IRQ_MASK, 32'h0000_0000, rs);
        axi_rd(`A_IRQ_STAT, rd, rs);
        `CHK(rd[2:0], 3'b011)
        `CHK(irq, 1'b0)
        axi_wr(`A_IRQ_MASK, 32'h0000_0002, rs);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        axi_wr(`A_IRQ_STAT, 32'h0000_0002, rs);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        axi_rd(`A_IRQ_STAT, rd, rs);
        `CHK(rd[2:0], 3'b001)
        axi_wr(8'h20, 32'hFFFF_FFFF, rs);
        `CHK(rs, `RESP_SLVERR)
        axi_rd(8'h20, rd, rs);
        `CHK(rs, `RESP_SLVERR)
        `CHK(rd, 32'h0000_0000)
        $display("test irq done");
    endtask : t_irq

    task automatic t_restart;
        axi_wr(`A_CFG, 32'h0000_0008, rs);
        axi_wr(`A_IRQ_MASK, 32'h0000_0004, rs);
        repeat (2) @(posedge clk);
        `CHK(st_f, 1'b1)
        i_bus_master_model.clear();
        repeat (3) @(posedge clk);
        `CHK(init_f, 1'b1)
        `CHK(st_f, 1'b0)
        `CHK(b_rdy, 1'b0)
        `CHK(irq, 1'b1)
        i_bus_master_model.request(1'b0, g, dv, inv);
        `CHK(g, 1'b0)
        wait_for(init_f, 1'b0, `LINK_CYC + FILT + 300);
        `CHK(st_f, 1'b1)
        @(posedge clk);
        uv <= 1'b1;
        @(posedge clk);
        uv <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK(init_f, 1'b1)
        `CHK(b_rdy, 1'b0)
        wait_for(b_rdy, 1'b1, `LINK_CYC + 100);
        `CHK(init_f, 1'b1)
        i_bus_master_model.request(1'b1, g, dv, inv);
        `CHK(inv, 1'b1)
        `CHK(i_bus_master_model.good_q, 10'h020)
        wait_for(init_f, 1'b0, FILT + 100);
        `CHK(init_f, 1'b0)
        axi_wr(`A_IRQ_STAT, 32'h0000_0004, rs);
        axi_wr(`A_CFG, 32'h0000_0000, rs);
        $display("test restart done");
    endtask : t_restart

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done

    initial begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_power_up();
        t_interp();
        t_scale();
        t_pcm();
        t_irq();
        t_restart();
        test_done();
    end
endmodule : accel_output_and_init_tb
